/* verilog/aco_optimizer.v */
// adaptive charge optimizer: cycle sequencer and target learning
`timescale 1ns/100ps
`include "aco_defs.vh"

// Function
// - each nonzero profile keeps its own stored target
// - profile zero charges to fixed level
// - first use loads target from cap-max
// - register write or pin starts cycle
// - target reached begins active cycle
// - active end compares voltage to margin
// - above margin lowers target one step
// - below margin raises target
// - equal margin leaves target unchanged
// - power-on or profile reset reinitialises
// - far below margin raises two steps
// - moderately below raises one step
// - falling load keeps stepping target down
// - rising load keeps stepping target up
// - margin select defaults to binary 11
// - cap-max select picks starting target
// - profile index defaults to one
// - sixty-three learned profiles supported
// - index zero disables the optimizer
// - profile and margin set by host only
module aco_optimizer (
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire                     profMsbWr,
  input  wire [1:0]               profMsbData,
  input  wire                     cmdWr,
  input  wire [7:0]               cmdData,
  input  wire                     capMaxWr,
  input  wire                     capMaxData,
  input  wire                     marginWr,
  input  wire [`ACO_MARG_W-1:0]   marginData,
  input  wire                     fixWr,
  input  wire [`ACO_FIX_W-1:0]    fixData,
  input  wire                     startPin,
  input  wire [`ACO_LVL_W-1:0]    capVoltage,
  input  wire                     activeDone,
  output wire [`ACO_PROF_W-1:0]   profileIdx,
  output wire [`ACO_MARG_W-1:0]   marginSel,
  output wire                     capMaxSel,
  output wire [`ACO_FIX_W-1:0]    fixedLevel,
  output wire                     chargeEn,
  output wire                     activeEn,
  output wire                     busy,
  output wire [`ACO_LVL_W-1:0]    targetLevel,
  output wire [1:0]               lastAdjust,
  output wire                     updateDone
);

  // =========================================================
  // host configuration
  reg [`ACO_PROF_W-1:0] prof_q;
  reg [`ACO_MARG_W-1:0] marg_q;
  reg                   capMax_q;
  reg [`ACO_FIX_W-1:0]  fix_q;

  // low index bits ride in the upper nibble of the command byte
  function [`ACO_PROF_W-1:0] joinIndex;
    input [`ACO_PROF_W-`ACO_PROF_SPLIT-1:0] hi;
    input [7:0]                              cmd;
    begin
      joinIndex = {hi, cmd[`ACO_CMD_PROF_HI:`ACO_CMD_PROF_LO]};
    end
  endfunction

  wire startReg = cmdWr & cmdData[`ACO_BIT_START];
  wire rstProf  = cmdWr & cmdData[`ACO_BIT_RSTPF];
  // index travels with the reset bit in the same write
  wire [`ACO_PROF_W-1:0] cmdProf =
    joinIndex(prof_q[`ACO_PROF_W-1:`ACO_PROF_SPLIT], cmdData);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prof_q   <= `ACO_PROF_RST;
      marg_q   <= `ACO_MARG_RST;
      capMax_q <= `ACO_CAPMAX_RST;
      fix_q    <= `ACO_FIX_RST;
    end else begin
      // index halves come by separate strobes; both at once pair up
      if (profMsbWr && cmdWr) begin
        prof_q <= joinIndex(profMsbData, cmdData);
      end else if (profMsbWr) begin
        prof_q <= {profMsbData, prof_q[`ACO_PROF_SPLIT-1:0]};
      end else if (cmdWr) begin
        prof_q <= cmdProf;
      end
      if (marginWr) begin
        marg_q <= marginData;
      end
      if (capMaxWr) begin
        capMax_q <= capMaxData;
      end
      if (fixWr) begin
        fix_q <= fixData;
      end
    end
  end

  // =========================================================
  // decode helpers
  // margin codes map to rising thresholds
  function [`ACO_LVL_W-1:0] marginLevel;
    input [`ACO_MARG_W-1:0] sel;
    begin
      case (sel)
        2'h0:    marginLevel = `ACO_MARG_T0;
        2'h1:    marginLevel = `ACO_MARG_T1;
        2'h2:    marginLevel = `ACO_MARG_T2;
        default: marginLevel = `ACO_MARG_T3;
      endcase
    end
  endfunction

  function [`ACO_LVL_W-1:0] capMaxLevel;
    input sel;
    begin
      if (sel) begin
        capMaxLevel = `ACO_CAPMAX_HI;
      end else begin
        capMaxLevel = `ACO_CAPMAX_LO;
      end
    end
  endfunction

  // =========================================================
  // learning step
  // saturating arithmetic keeps the code inside the cap range
  function [`ACO_LVL_W+1:0] learnStep;
    input [`ACO_LVL_W-1:0] cur;
    input [`ACO_LVL_W-1:0] vcap;
    input [`ACO_LVL_W-1:0] thr;
    reg   [`ACO_LVL_W-1:0] gap;
    reg   [`ACO_LVL_W-1:0] step;
    reg   [`ACO_LVL_W:0]   sum;
    begin
      // gap only means something when vcap sits below thr
      gap  = thr - vcap;
      step = `ACO_STEP_ONE;
      sum  = {1'b0, cur};
      if (vcap > thr) begin
        if (cur == `ACO_LVL_MIN) begin
          learnStep = {`ACO_ADJ_DOWN, cur};
        end else begin
          learnStep = {`ACO_ADJ_DOWN, cur - `ACO_STEP_ONE};
        end
      end else if (vcap < thr) begin
        if (gap >= `ACO_FAR_GAP) begin
          step = `ACO_STEP_TWO;
        end
        sum = {1'b0, cur} + {1'b0, step};
        if (sum > {1'b0, `ACO_LVL_MAX}) begin
          sum = {1'b0, `ACO_LVL_MAX};
        end
        if (step == `ACO_STEP_TWO) begin
          learnStep = {`ACO_ADJ_UP2, sum[`ACO_LVL_W-1:0]};
        end else begin
          learnStep = {`ACO_ADJ_UP1, sum[`ACO_LVL_W-1:0]};
        end
      end else begin
        learnStep = {`ACO_ADJ_HOLD, cur};
      end
    end
  endfunction

  // =========================================================
  // profile storage
  reg  [`ACO_STATE_W-1:0] state_q;
  reg  [`ACO_STATE_W-1:0] state_d;
  reg  [`ACO_PROF_W-1:0]  cycProf_q;
  reg  [`ACO_LVL_W-1:0]   target_q;
  reg  [`ACO_LVL_W-1:0]   target_d;
  reg  [1:0]              adj_q;
  reg  [1:0]              adj_d;
  reg                     done_q;
  reg                     wrEn;
  reg  [`ACO_LVL_W-1:0]   wrData;
  wire [`ACO_LVL_W-1:0]   storeLvl;
  wire                    storeValid;
  wire [`ACO_LVL_W+1:0]   stepOut;

  assign stepOut = learnStep(target_q, capVoltage, marginLevel(marg_q));

  // 64 slots, slot zero never written since index zero is off
  // a write to a slot wins over a clear of it in the same cycle
  aco_profile_store uStore (
    .clk     (clk),
    .rst_n   (rst_n),
    .rdIdx   (cycProf_q),
    .rdData  (storeLvl),
    .rdValid (storeValid),
    .wrEn    (wrEn),
    .wrIdx   (cycProf_q),
    .wrData  (wrData),
    .clrEn   (rstProf),
    .clrIdx  (cmdProf)
  );

  // =========================================================
  // sequencer states
  localparam [`ACO_STATE_W-1:0] ST_IDLE   = `ACO_ST_IDLE;
  localparam [`ACO_STATE_W-1:0] ST_LOAD   = `ACO_ST_LOAD;
  localparam [`ACO_STATE_W-1:0] ST_CHARGE = `ACO_ST_CHARGE;
  localparam [`ACO_STATE_W-1:0] ST_ACTIVE = `ACO_ST_ACTIVE;
  localparam [`ACO_STATE_W-1:0] ST_UPDATE = `ACO_ST_UPDATE;

  // =========================================================
  // cycle sequencer
  // a start seen outside idle is dropped, not queued
  wire startAny = startReg | startPin;

  always @* begin
    state_d  = state_q;
    target_d = target_q;
    adj_d    = adj_q;
    wrEn     = 1'b0;
    wrData   = target_q;
    case (state_q)
      ST_IDLE: begin
        if (startAny) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_d = ST_CHARGE;
        if (cycProf_q == `ACO_PROF_OFF) begin
          target_d = {1'b0, fix_q};
        end else if (storeValid) begin
          target_d = storeLvl;
        end else begin
          // first use seeds the slot so the next cycle learns from it
          target_d = capMaxLevel(capMax_q);
          wrEn     = 1'b1;
          wrData   = target_d;
        end
      end
      ST_CHARGE: begin
        // no timeout: a supply that never gets there holds the cycle
        if (capVoltage >= target_q) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (activeDone) begin
          state_d = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        // single write per active cycle, done before idle
        state_d = ST_IDLE;
        if (cycProf_q != `ACO_PROF_OFF) begin
          target_d = stepOut[`ACO_LVL_W-1:0];
          adj_d    = stepOut[`ACO_LVL_W+1:`ACO_LVL_W];
          wrEn     = 1'b1;
          wrData   = target_d;
        end else begin
          // profile zero keeps its fixed target and never learns
          adj_d = `ACO_ADJ_HOLD;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      cycProf_q <= `ACO_PROF_RST;
      target_q  <= `ACO_LVL_MIN;
      adj_q     <= `ACO_ADJ_HOLD;
      done_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      target_q <= target_d;
      adj_q    <= adj_d;
      done_q   <= (state_q == ST_UPDATE);
      if (state_q == ST_IDLE) begin
        // profile frozen for the whole cycle
        cycProf_q <= prof_q;
      end
    end
  end

  // =========================================================
  // outputs
  assign profileIdx  = prof_q;
  assign marginSel   = marg_q;
  assign capMaxSel   = capMax_q;
  assign fixedLevel  = fix_q;
  assign chargeEn    = (state_q == ST_CHARGE);
  assign activeEn    = (state_q == ST_ACTIVE);
  assign busy        = (state_q != ST_IDLE);
  assign targetLevel = target_q;
  assign lastAdjust  = adj_q;
  assign updateDone  = done_q;

endmodule

/* verilog/aco_defs.vh */
// constants for the adaptive charge optimizer
`ifndef ACO_DEFS_VH
`define ACO_DEFS_VH

// widths
`define ACO_LVL_W        5
`define ACO_PROF_W       6
`define ACO_MARG_W       2
`define ACO_FIX_W        4
`define ACO_STATE_W      3
`define ACO_PROF_CNT     64

// control field placements (host register image)
`define ACO_REG_PROF_MSB 8'h07
`define ACO_REG_COMMAND  8'h08
`define ACO_BIT_RSTPF    3
`define ACO_BIT_START    0
`define ACO_CMD_PROF_HI  7
`define ACO_CMD_PROF_LO  4
`define ACO_PROF_SPLIT   4
`define ACO_REG_SET4     8'h0c
`define ACO_BIT_CAPMAX   4
`define ACO_REG_SET5     8'h0d

// reset values
`define ACO_PROF_RST     6'h01
`define ACO_MARG_RST     2'h3
`define ACO_CAPMAX_RST   1'b0
`define ACO_FIX_RST      4'h0
`define ACO_PROF_OFF     6'h00

// level codes
`define ACO_CAPMAX_HI    5'h0f
`define ACO_CAPMAX_LO    5'h0b
`define ACO_LVL_MIN      5'h00
`define ACO_LVL_MAX      5'h1f
`define ACO_MARG_T0      5'h01
`define ACO_MARG_T1      5'h02
`define ACO_MARG_T2      5'h03
`define ACO_MARG_T3      5'h04
`define ACO_FAR_GAP      5'h03
`define ACO_STEP_ONE     5'h01
`define ACO_STEP_TWO     5'h02

// adjustment codes reported after each update
`define ACO_ADJ_HOLD     2'h0
`define ACO_ADJ_DOWN     2'h1
`define ACO_ADJ_UP1      2'h2
`define ACO_ADJ_UP2      2'h3

// state codes
`define ACO_ST_IDLE      3'h0
`define ACO_ST_LOAD      3'h1
`define ACO_ST_CHARGE    3'h2
`define ACO_ST_ACTIVE    3'h3
`define ACO_ST_UPDATE    3'h4

`endif

/* verilog/aco_profile_store.v */
// per-profile learned target storage with valid bits
`timescale 1ns/100ps
`include "aco_defs.vh"
module aco_profile_store (
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire [`ACO_PROF_W-1:0]   rdIdx,
  output wire [`ACO_LVL_W-1:0]    rdData,
  output wire                     rdValid,
  input  wire                     wrEn,
  input  wire [`ACO_PROF_W-1:0]   wrIdx,
  input  wire [`ACO_LVL_W-1:0]    wrData,
  input  wire                     clrEn,
  input  wire [`ACO_PROF_W-1:0]   clrIdx
);

  // =========================================================
  // storage
  // array holds no reset; the valid bits gate it instead
  reg  [`ACO_LVL_W-1:0]    levelMem [0:`ACO_PROF_CNT-1];
  wire [`ACO_PROF_CNT-1:0] valid_q;

  always @(posedge clk) begin
    if (wrEn) begin
      levelMem[wrIdx] <= wrData;
    end
  end

  // =========================================================
  // valid bits
  genvar gi;
  generate
    for (gi = 0; gi < `ACO_PROF_CNT; gi = gi + 1) begin : gValid
      reg validBit_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          validBit_q <= 1'b0;
        end else if (wrEn && wrIdx == gi) begin
          // a write in the clear cycle wins
          validBit_q <= 1'b1;
        end else if (clrEn && clrIdx == gi) begin
          validBit_q <= 1'b0;
        end
      end
      assign valid_q[gi] = validBit_q;
    end
  endgenerate

  assign rdData  = levelMem[rdIdx];
  assign rdValid = valid_q[rdIdx];

endmodule

/* tb/aco_optimizer_asserts.sv */
// checker for the adaptive charge optimizer ports
`timescale 1ns/100ps
module aco_optimizer_chk (
  input wire       clk,
  input wire       rst_n,
  input wire       startPin,
  input wire [4:0] capVoltage,
  input wire       activeDone,
  input wire       marginWr,
  input wire [1:0] marginData,
  input wire       capMaxWr,
  input wire       capMaxData,
  input wire [1:0] marginSel,
  input wire       capMaxSel,
  input wire       chargeEn,
  input wire       activeEn,
  input wire       busy,
  input wire [4:0] targetLevel,
  input wire [1:0] lastAdjust,
  input wire       updateDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // assertions
  a_start_busy: assert property (!busy && startPin |=> busy)
    else $error("start in idle did not raise busy");
  a_charge_stop: assert property (
    chargeEn && capVoltage >= targetLevel |=> !chargeEn && activeEn)
    else $error("charge did not hand over to active");
  a_active_end: assert property (
    activeEn && activeDone |=> !activeEn && busy ##1 updateDone && !busy)
    else $error("active end did not yield one update");
  a_done_pulse: assert property (updateDone |=> !updateDone)
    else $error("update pulse too long");
  a_idle_quiet: assert property (!busy |-> !chargeEn && !activeEn)
    else $error("charge or active outside a cycle");
  a_target_steady: assert property (
    (chargeEn && $past(chargeEn)) || activeEn |-> $stable(targetLevel))
    else $error("target moved inside a cycle");
  a_down_one: assert property (
    updateDone && lastAdjust == 2'h1 && $past(targetLevel) != 5'h00
    |-> targetLevel == $past(targetLevel) - 5'h01)
    else $error("down step not one");
  a_up_one: assert property (
    updateDone && lastAdjust == 2'h2 && $past(targetLevel) != 5'h1f
    |-> targetLevel == $past(targetLevel) + 5'h01)
    else $error("single up step wrong");
  a_up_two: assert property (
    updateDone && lastAdjust == 2'h3 && $past(targetLevel) < 5'h1e
    |-> targetLevel == $past(targetLevel) + 5'h02)
    else $error("double up step wrong");
  a_margin_wr: assert property (
    marginWr |=> marginSel == $past(marginData))
    else $error("margin write lost");
  a_capmax_wr: assert property (
    capMaxWr |=> capMaxSel == $past(capMaxData))
    else $error("cap-max write lost");
  c_down: cover property (updateDone && lastAdjust == 2'h1);
  c_up1: cover property (updateDone && lastAdjust == 2'h2);
  c_up2: cover property (updateDone && lastAdjust == 2'h3);
  c_hold: cover property (updateDone && lastAdjust == 2'h0);
endmodule
bind aco_optimizer aco_optimizer_chk u_chk (.clk, .rst_n, .startPin,
  .capVoltage, .activeDone, .marginWr, .marginData, .capMaxWr,
  .capMaxData, .marginSel, .capMaxSel, .chargeEn, .activeEn, .busy,
  .targetLevel, .lastAdjust, .updateDone);

/* tb/aco_cap_model.sv */
// storage capacitor and load model driving the measured level
`timescale 1ns/100ps
module aco_cap_model (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       chargeEn,
  input  wire       activeEn,
  input  wire [4:0] endLevel,
  output reg  [4:0] capVoltage,
  output reg        activeDone
);
  reg [2:0] cnt_q;
  // ==========
  // charge ramps one code a cycle; load drains to endLevel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capVoltage <= 5'h00;
      cnt_q      <= 3'h0;
      activeDone <= 1'b0;
    end else begin
      activeDone <= 1'b0;
      cnt_q      <= activeEn ? cnt_q + 3'h1 : 3'h0;
      if (chargeEn && capVoltage < 5'h1f) begin
        capVoltage <= capVoltage + 5'h01;
      end
      if (activeEn && cnt_q == 3'h3) begin
        capVoltage <= endLevel;
        activeDone <= 1'b1;
      end
    end
  end
endmodule

/* tb/test_aco_optimizer.sv */
// self-checking bench for the adaptive charge optimizer
`timescale 1ns/100ps
module test_aco_optimizer;
  reg clk = 0, rst_n = 0, startPin = 0;
  reg profMsbWr = 0, cmdWr = 0, capMaxWr = 0, marginWr = 0, fixWr = 0;
  reg [1:0] profMsbData = 0, marginData = 0;
  reg [7:0] cmdData = 0;
  reg       capMaxData = 0;
  reg [3:0] fixData = 0;
  reg [4:0] endLvl = 0;
  wire [4:0] capVoltage, targetLevel;
  wire [5:0] profileIdx;
  wire [1:0] marginSel, lastAdjust;
  wire [3:0] fixedLevel;
  wire activeDone, capMaxSel, chargeEn, activeEn, busy, updateDone;
  int n_errors = 0, checks = 0, cycCnt = 0;
  aco_optimizer uut (.clk, .rst_n, .profMsbWr, .profMsbData, .cmdWr,
    .cmdData, .capMaxWr, .capMaxData, .marginWr, .marginData, .fixWr,
    .fixData, .startPin, .capVoltage, .activeDone, .profileIdx,
    .marginSel, .capMaxSel, .fixedLevel, .chargeEn, .activeEn, .busy,
    .targetLevel, .lastAdjust, .updateDone);
  aco_cap_model cap (.clk, .rst_n, .chargeEn, .activeEn,
    .endLevel(endLvl), .capVoltage, .activeDone);
  initial forever #10 clk = ~clk;
  // ==========
  // tasks
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one-cycle strobe: 0 cmd, 1 capmax, 2 margin, 3 fixed, 4 index msb
  task wr(input int k, input logic [7:0] d);
    @(posedge clk) #1;
    case (k)
      0: begin cmdWr = 1; cmdData = d; end
      1: begin capMaxWr = 1; capMaxData = d[0]; end
      2: begin marginWr = 1; marginData = d[1:0]; end
      3: begin fixWr = 1; fixData = d[3:0]; end
      default: begin profMsbWr = 1; profMsbData = d[1:0]; end
    endcase
    @(posedge clk) #1;
    {cmdWr, capMaxWr, marginWr, fixWr, profMsbWr} = 5'h00;
  endtask
  // full cycle: loaded target, learned target, adjust code
  task cyc(input logic pin, input logic [4:0] e, lo, nx,
           input logic [1:0] a);
    int i;
    endLvl = e;
    @(posedge clk) #1;
    if (pin) startPin = 1;
    else begin cmdWr = 1; cmdData = {profileIdx[3:0], 4'h1}; end
    @(posedge clk) #1;
    startPin = 0;
    cmdWr = 0;
    for (i = 0; i < 50 && chargeEn !== 1'b1; i++) @(posedge clk) #1;
    chk({3'h0, targetLevel}, {3'h0, lo});
    for (i = 0; i < 200 && updateDone !== 1'b1; i++) @(posedge clk) #1;
    chk({3'h0, targetLevel}, {3'h0, nx});
    chk({6'h0, lastAdjust}, {6'h0, a});
  endtask
  always @(posedge clk) begin
    cycCnt++;
    if (cycCnt == 20000) begin
      n_errors++;
      test_done;
    end
  end
  // ==========
  // sequence
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    chk({2'h0, profileIdx}, 8'h01);
    chk({6'h0, marginSel}, 8'h03);
    chk({7'h0, capMaxSel}, 8'h00);
    wr(1, 8'h01);
    chk({7'h0, capMaxSel}, 8'h01);
    cyc(1, 5'h05, 5'h0f, 5'h0e, 2'h1);
    cyc(0, 5'h04, 5'h0e, 5'h0e, 2'h0);
    cyc(1, 5'h00, 5'h0e, 5'h10, 2'h3);
    cyc(1, 5'h02, 5'h10, 5'h11, 2'h2);
    cyc(1, 5'h05, 5'h11, 5'h10, 2'h1);
    wr(0, 8'h18);
    cyc(1, 5'h04, 5'h0f, 5'h0f, 2'h0);
    wr(1, 8'h00);
    wr(0, 8'h20);
    cyc(1, 5'h04, 5'h0b, 5'h0b, 2'h0);
    wr(4, 8'h03);
    wr(0, 8'hf0);
    chk({2'h0, profileIdx}, 8'h3f);
    cyc(1, 5'h03, 5'h0b, 5'h0c, 2'h2);
    wr(4, 8'h00);
    wr(0, 8'h10);
    cyc(1, 5'h04, 5'h0f, 5'h0f, 2'h0);
    wr(2, 8'h00);
    chk({6'h0, marginSel}, 8'h00);
    cyc(1, 5'h02, 5'h0f, 5'h0e, 2'h1);
    wr(2, 8'h02);
    chk({6'h0, marginSel}, 8'h02);
    cyc(1, 5'h03, 5'h0e, 5'h0e, 2'h0);
    wr(2, 8'h01);
    cyc(1, 5'h03, 5'h0e, 5'h0d, 2'h1);
    wr(3, 8'h09);
    wr(0, 8'h00);
    chk({4'h0, fixedLevel}, 8'h09);
    cyc(0, 5'h00, 5'h09, 5'h09, 2'h0);
    test_done;
  end
endmodule
